// ### bench/hied_desc_assertions.sv
`timescale 1ns/100ps
module hied_desc_chk
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        multi_translator_enable_i,
  input wire logic        start_i,
  input wire logic        ready_i,
  input wire logic        valid_o,
  input wire logic [7:0]  data_o,
  input wire logic        last_o,
  input wire logic [15:0] total_length_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire tk = valid_o && ready_i;
  first_byte_a: assert property (start_i && !valid_o |=> valid_o && data_o == 8'h09)
    else $error("bad first byte");
  total_len_a: assert property (1 |=> total_length_o ==
    ($past(multi_translator_enable_i) ? 16'h0029 : 16'h0019)) else $error("bad total");
  byte_hold_a: assert property (valid_o && !ready_i |=> valid_o && $stable(data_o))
    else $error("byte not held");
  stream_end_a: assert property (tk && last_o |=> !valid_o) else $error("no end");
  ep_addr_a: assert property (tk && data_o == 8'h05 |=> data_o == 8'h81)
    else $error("bad address");
  ep_attr_a: assert property (tk && data_o == 8'h81 |=> data_o == 8'h03)
    else $error("bad attributes");
  ep_size_a: assert property (tk && data_o == 8'h03 |=> data_o == 8'h01)
    else $error("bad packet size");
  ep_interval_a: assert property (last_o |-> valid_o && data_o == 8'h0C)
    else $error("bad interval");
  cover property (tk && last_o);
  cover property (valid_o && !ready_i);
  cover property (start_i && valid_o);
endmodule
bind hied_desc hied_desc_chk u_chk (.*);

// ### bench/hied_desc_tb_top.sv
`timescale 1ns/100ps
module hied_desc_tb_top;
  logic        clk_i = 0, rst_i = 1, start_i = 0, ready_i, valid_o, last_o, busy_o;
  logic        multi_translator_enable_i = 0;
  logic [7:0]  num_interfaces_i = 8'h01, data_o;
  logic [15:0] total_length_o;
  logic [8:0]  q[$];
  logic [7:0]  b[16];
  integer      n_fail = 0, tests_run = 0, seed = 68058;
  initial forever #12.5 clk_i = ~clk_i;
  hied_desc dut (.*);
  hied_host host (.clk_i(clk_i), .rst_i(rst_i), .ready_o(ready_i));
  task cmp(input string nm, input logic [15:0] e, s);
    tests_run++;
    n_fail += (s !== e);
    if (s !== e)
      $display("MISMATCH %s exp %h got %h", nm, e, s);
  endtask
  task test_done;
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Last flag rides in bit 8 of each note
  task run(input logic e, input logic [7:0] n);
    b = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00,
          8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C};
    b[7] = (n == 8'h02) ? 8'h01 : 8'h00;
    for (int i = 0; i < 16; i++) q.push_back({!e && i == 15, b[i]});
    b[3] = 8'h01;
    b[7] = 8'h02;
    for (int i = 0; e && i < 16; i++) q.push_back({i == 15, b[i]});
    @(posedge clk_i);
    multi_translator_enable_i <= e;
    num_interfaces_i <= n;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    #1 cmp("total", e ? 16'h0029 : 16'h0019, total_length_o);
    cmp("busy", 16'h0001, {15'h0000, busy_o});
    while (q.size() != 0)
      @(posedge clk_i) #1;
    cmp("idle", 16'h0000, {15'h0000, busy_o});
  endtask
  always @(posedge clk_i)
    if (valid_o === 1'b1 && ready_i === 1'b1)
      cmp("byte", {7'h00, q.pop_front()}, {7'h00, last_o, data_o});
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 6; k++)
      run(k[0], k < 2 ? 8'h01 : k < 4 ? 8'h02 : 8'($random(seed)));
    test_done;
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    test_done;
  end
endmodule

// ### bench/hied_host.sv
`timescale 1ns/100ps
module hied_host
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      ready_o
);
  integer seed = 68058;
  // Random stalls hold ready low on about one cycle in four
  always @(posedge clk_i or posedge rst_i)
    ready_o <= rst_i ? 1'b0 : ($random(seed) & 3) != 0;
endmodule

// ### hdl/hied_desc.sv
// Operation
// R1: Single interface descriptor: length 09h, type 04h, number 00h, alternate 00h.
// R2: Interface descriptors declare one endpoint, hub class 09h, subclass 00h.
// R3: Single interface protocol 00h for one interface, 01h for two interfaces.
// R4: Both interface descriptors give string index 00h.
// R5: Multi interface matches single, but alternate 01h and protocol 02h.
// R6: Multi interface and its endpoint sent only when multi-translator enabled.
// R7: Endpoint descriptor: length 07h, type 05h, address 81h.
// R8: Endpoint attributes 03h, interrupt, no synchronization.
// R9: Endpoint maximum packet size 0001h, two bytes.
// R10: Endpoint polling interval 0Ch.
// R11: Multi endpoint descriptor identical to the single endpoint descriptor.
// R12: Total length reported 0019h when enable clear, 0029h when set.
// R13: Order single interface, endpoint, then multi pair; fields LSB first.
`timescale 1ns/100ps
`include "hied_map.svh"
// Interface descriptor table; ALT_SEL sets the alternate setting byte
module hied_if_rom
#(
  parameter logic [7:0] ALT_SEL = `HIED_ALT_SINGLE
)
(
  input  wire logic [5:0] off_i,
  input  wire logic [7:0] proto_i,
  output logic      [7:0] byte_o
);
  always_comb
  begin
    unique case (off_i)
      `HIED_IF_OFF_LEN:
      begin
        byte_o = `HIED_IF_LEN; // [R1] [R5]
      end
      `HIED_IF_OFF_TYPE:
      begin
        byte_o = `HIED_IF_TYPE; // [R1] [R5]
      end
      `HIED_IF_OFF_NUM:
      begin
        byte_o = `HIED_IF_NUM; // [R1] [R5]
      end
      `HIED_IF_OFF_ALT:
      begin
        byte_o = ALT_SEL; // [R1] [R5]
      end
      `HIED_IF_OFF_NEP:
      begin
        byte_o = `HIED_NUM_EP; // [R2]
      end
      `HIED_IF_OFF_CLASS:
      begin
        byte_o = `HIED_CLASS_HUB; // [R2]
      end
      `HIED_IF_OFF_SUB:
      begin
        byte_o = `HIED_SUBCLASS; // [R2]
      end
      `HIED_IF_OFF_PROTO:
      begin
        byte_o = proto_i; // [R3] [R5]
      end
      `HIED_IF_OFF_STR:
      begin
        byte_o = `HIED_IF_STRING; // [R4]
      end
      default:
      begin
        byte_o = `HIED_DATA_RST;
      end
    endcase
  end
endmodule

// Status-change endpoint table, shared by both translator variants
module hied_ep_rom
(
  input  wire logic [5:0] off_i,
  output logic      [7:0] byte_o
);
  always_comb
  begin
    unique case (off_i)
      `HIED_EP_OFF_LEN:
      begin
        byte_o = `HIED_EP_LEN; // [R7] [R11]
      end
      `HIED_EP_OFF_TYPE:
      begin
        byte_o = `HIED_EP_TYPE; // [R7] [R11]
      end
      `HIED_EP_OFF_ADDR:
      begin
        byte_o = `HIED_EP_ADDR; // [R7] [R11]
      end
      `HIED_EP_OFF_ATTR:
      begin
        byte_o = `HIED_EP_ATTR; // [R8] [R11]
      end
      `HIED_EP_OFF_MPSL:
      begin
        byte_o = `HIED_EP_MPS_LO; // [R9] [R13]
      end
      `HIED_EP_OFF_MPSH:
      begin
        byte_o = `HIED_EP_MPS_HI; // [R9] [R13]
      end
      `HIED_EP_OFF_IVAL:
      begin
        byte_o = `HIED_EP_INTERVAL; // [R10] [R11]
      end
      default:
      begin
        byte_o = `HIED_DATA_RST;
      end
    endcase
  end
endmodule

// Streams the descriptor bytes one per accepted handshake
module hied_desc
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       multi_translator_enable_i,
  input  wire logic [7:0] num_interfaces_i,
  input  wire logic       start_i,
  input  wire logic       ready_i,
  output logic            valid_o,
  output logic [7:0]      data_o,
  output logic            last_o,
  output logic            busy_o,
  output logic [15:0]     total_length_o
);
  hied_pkg::hied_state_t state_reg;
  hied_pkg::hied_state_t state_next;
  logic [5:0]            idx_reg;
  logic [5:0]            idx_next;
  logic                  multi_reg;
  logic                  multi_next;
  logic [7:0]            data_reg;
  logic [7:0]            data_next;
  logic [15:0]           total_reg;
  logic [15:0]           total_next;
  logic [5:0]            last_idx;
  logic [5:0]            off;
  logic [5:0]            fetch_idx;
  logic [7:0]            proto_single;
  logic [7:0]            if_single_byte;
  logic [7:0]            if_multi_byte;
  logic [7:0]            ep_single_byte;
  logic [7:0]            ep_multi_byte;
  logic [7:0]            byte_val;

  // Enable is sampled at start so a frame never changes shape midway
  assign last_idx     = multi_reg ? `HIED_LAST_MULTI : `HIED_LAST_SINGLE; // [R6]
  // Protocol follows the live count; the host must hold it during a frame
  assign proto_single = (num_interfaces_i == `HIED_NUMIF_TWO) ? `HIED_PROTO_TWO
                        : `HIED_PROTO_ONE; // [R3]

  // Offset of the fetched byte inside its own descriptor
  always_comb
  begin
    off = `HIED_IDX_ZERO;
    if (fetch_idx < `HIED_SEG_EP)
    begin
      off = fetch_idx;
    end
    else if (fetch_idx < `HIED_SEG_IF2)
    begin
      off = fetch_idx - `HIED_SEG_EP;
    end
    else if (fetch_idx < `HIED_SEG_EP2)
    begin
      off = fetch_idx - `HIED_SEG_IF2;
    end
    else
    begin
      off = fetch_idx - `HIED_SEG_EP2;
    end
  end

  // One table per descriptor; the endpoint pair is identical by design
  hied_if_rom
  #(
    .ALT_SEL (`HIED_ALT_SINGLE)
  )
  u_if_single
  (
    .off_i   (off),
    .proto_i (proto_single),
    .byte_o  (if_single_byte)
  );
  hied_ep_rom u_ep_single
  (
    .off_i  (off),
    .byte_o (ep_single_byte)
  );
  hied_if_rom
  #(
    .ALT_SEL (`HIED_ALT_MULTI)
  )
  u_if_multi
  (
    .off_i   (off),
    .proto_i (`HIED_PROTO_MULTI),
    .byte_o  (if_multi_byte)
  );
  hied_ep_rom u_ep_multi
  (
    .off_i  (off),
    .byte_o (ep_multi_byte)
  );

  // Segment select: fetch_idx picks which byte data_reg will hold next
  always_comb
  begin
    byte_val = if_single_byte;
    if (fetch_idx < `HIED_SEG_EP)
    begin
      byte_val = if_single_byte; // [R13]
    end
    else if (fetch_idx < `HIED_SEG_IF2)
    begin
      byte_val = ep_single_byte; // [R13]
    end
    else if (fetch_idx < `HIED_SEG_EP2)
    begin
      byte_val = if_multi_byte; // [R13]
    end
    else
    begin
      byte_val = ep_multi_byte; // [R13]
    end
  end

  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    multi_next = multi_reg;
    data_next  = data_reg;
    total_next = multi_translator_enable_i ? `HIED_TOTAL_MULTI : `HIED_TOTAL_SINGLE; // [R12]
    fetch_idx  = `HIED_IDX_ZERO;
    unique case (state_reg)
      hied_pkg::HIED_IDLE:
      begin
        if (start_i)
        begin
          state_next = hied_pkg::HIED_SEND;
          idx_next   = `HIED_IDX_ZERO;
          multi_next = multi_translator_enable_i; // [R6]
          fetch_idx  = `HIED_IDX_ZERO;
          data_next  = byte_val;
        end
      end
      hied_pkg::HIED_SEND:
      begin
        fetch_idx = idx_reg + `HIED_IDX_ONE;
        if (ready_i)
        begin
          if (idx_reg == last_idx)
            state_next = hied_pkg::HIED_IDLE; // [R6]
          else
          begin
            idx_next  = idx_reg + `HIED_IDX_ONE; // [R13]
            data_next = byte_val;
          end
        end
      end
      default:
      begin
        state_next = hied_pkg::HIED_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= hied_pkg::HIED_IDLE;
      idx_reg   <= `HIED_IDX_ZERO;
      multi_reg <= 1'b0;
      data_reg  <= `HIED_DATA_RST;
      total_reg <= `HIED_TOTAL_SINGLE;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      multi_reg <= multi_next;
      data_reg  <= data_next;
      total_reg <= total_next;
    end
  end

  assign valid_o        = (state_reg == hied_pkg::HIED_SEND);
  assign busy_o         = (state_reg == hied_pkg::HIED_SEND);
  assign last_o         = valid_o && (idx_reg == last_idx);
  assign data_o         = data_reg;
  assign total_length_o = total_reg;
endmodule

// ### hdl/hied_map.svh
`ifndef HIED_MAP_SVH
`define HIED_MAP_SVH
`define HIED_IF_LEN       8'h09
`define HIED_IF_TYPE      8'h04
`define HIED_IF_NUM       8'h00
`define HIED_ALT_SINGLE   8'h00
`define HIED_ALT_MULTI    8'h01
`define HIED_NUM_EP       8'h01
`define HIED_CLASS_HUB    8'h09
`define HIED_SUBCLASS     8'h00
`define HIED_PROTO_ONE    8'h00
`define HIED_PROTO_TWO    8'h01
`define HIED_PROTO_MULTI  8'h02
`define HIED_IF_STRING    8'h00
`define HIED_EP_LEN       8'h07
`define HIED_EP_TYPE      8'h05
`define HIED_EP_ADDR      8'h81
`define HIED_EP_ATTR      8'h03
`define HIED_EP_MPS_LO    8'h01
`define HIED_EP_MPS_HI    8'h00
`define HIED_EP_INTERVAL  8'h0C
`define HIED_TOTAL_SINGLE 16'h0019
`define HIED_TOTAL_MULTI  16'h0029
`define HIED_NUMIF_TWO    8'h02
`define HIED_IDX_ZERO     6'h00
`define HIED_IDX_ONE      6'h01
`define HIED_LAST_SINGLE  6'h0F
`define HIED_LAST_MULTI   6'h1F
`define HIED_SEG_EP       6'h09
`define HIED_SEG_IF2      6'h10
`define HIED_SEG_EP2      6'h19
`define HIED_DATA_RST     8'h00
`define HIED_IF_OFF_LEN   6'h00
`define HIED_IF_OFF_TYPE  6'h01
`define HIED_IF_OFF_NUM   6'h02
`define HIED_IF_OFF_ALT   6'h03
`define HIED_IF_OFF_NEP   6'h04
`define HIED_IF_OFF_CLASS 6'h05
`define HIED_IF_OFF_SUB   6'h06
`define HIED_IF_OFF_PROTO 6'h07
`define HIED_IF_OFF_STR   6'h08
`define HIED_EP_OFF_LEN   6'h00
`define HIED_EP_OFF_TYPE  6'h01
`define HIED_EP_OFF_ADDR  6'h02
`define HIED_EP_OFF_ATTR  6'h03
`define HIED_EP_OFF_MPSL  6'h04
`define HIED_EP_OFF_MPSH  6'h05
`define HIED_EP_OFF_IVAL  6'h06
`endif

// ### hdl/hied_pkg.sv
package hied_pkg;
  typedef enum logic [1:0]
  {
    HIED_IDLE = 2'b00,
    HIED_SEND = 2'b01
  } hied_state_t;
endpackage
